// ### i2c_regport_pkg.sv
// Shared constants and types for the register-access serial port and its master
package i2c_regport_pkg;
	// ----------------------------------------
	// Bus geometry
	// ----------------------------------------
	localparam int ADDR_W = 7;                 // Target address width
	localparam int DATA_W = 8;                 // Register and bus byte width
	localparam logic [6:0] DEV_ADDR = 7'h20;   // Default target address
	localparam logic [7:0] PTR_RESET = 8'h00;  // Pointer after power-up
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 100;                        // System clock rate
	localparam int ACCESS_DELAY_US = 100;                // Power-up access delay, us
	localparam int ACCESS_DELAY_CYC = ACCESS_DELAY_US * CLK_MHZ;  // Cycles of delay
	localparam int HALF_BIT_CYC = 250;                   // Master half bit period
	// ----------------------------------------
	// Master command codes
	// ----------------------------------------
	typedef enum logic [1:0] {
		CMD_WRITE,      // Address, sub-address, data bytes
		CMD_SET_PTR,    // Address, sub-address, stop
		CMD_READ_CUR,   // Read from current pointer
		CMD_READ_SUB    // Sub-address, repeated start, read
	} cmd_type;
endpackage

// ### i2c_regport_if.sv
// Two-wire bus between register port and master, with open-drain resolution
`timescale 1ns/10ps
interface i2c_regport_if;
	logic scl_oe;      // Master pulls clock low
	logic sda_m_oe;    // Master pulls data low
	logic sda_s_oe;    // Device pulls data low
	logic scl;         // Resolved clock level
	logic sda;         // Resolved data level
	// Pull-ups give a high line when nobody drives low
	assign scl = ~scl_oe;
	assign sda = ~(sda_m_oe | sda_s_oe);
	modport device (input scl, input sda, output sda_s_oe);
	modport master (input scl, input sda, output scl_oe, output sda_m_oe);
endinterface // i2c_regport_if

// ### i2c_regport_slave.sv
// Device end: serial register-access target with sub-address pointer
// How it works
// [RULE1] Start, address, write bit; device acknowledges address
// [RULE2] One sub-address byte MSB first, acknowledged
// [RULE3] Each write data byte acknowledged, stored, incremented
// [RULE4] Master ends every write with a stop
// [RULE5] Plain read starts at pointer, MSB first
// [RULE6] Read after write starts at written sub-address
// [RULE7] ACK sends next byte; NACK releases, awaits stop
// [RULE8] Combined read: sub-address, repeated start, read
// [RULE9] Address plus sub-address only loads the pointer
// [RULE10] Pointer increments per read byte, ACK or not
// [RULE11] After power-up reads begin at register zero
// [RULE12] Bus ignored until power-up access delay elapses
// [RULE13] No response while in dead-battery mode
// [RULE14] Plain read uses direction bit one
`timescale 1ns/10ps
module i2c_regport_slave
	import i2c_regport_pkg::*;
#(
	parameter logic [6:0] DEV_ADDRESS = DEV_ADDR,   // Target address
	parameter int ACCESS_DELAY = ACCESS_DELAY_CYC    // Power-up delay in cycles
) (
	input wire logic clk,
	input wire logic rst,                 // Power-up reset
	i2c_regport_if.device bus,
	input wire logic dead_battery,        // Dead-battery mode active
	input wire logic [7:0] reg_rdata,     // Register map read data at reg_addr
	output logic [7:0] reg_addr,          // Register pointer
	output logic [7:0] reg_wdata,         // Byte to store
	output logic reg_we,                  // One-cycle write strobe
	output logic access_ready             // Power-up delay elapsed
);
	import i2c_regport_pkg::*;

	initial begin
		if (ACCESS_DELAY < 1) $error("ACCESS_DELAY must be at least one cycle");
	end

	typedef enum {
		ST_IDLE,      // Waiting for start
		ST_ADDR,      // Shifting address byte
		ST_ADDR_ACK,  // Driving address acknowledge
		ST_SUB,       // Shifting sub-address byte
		ST_SUB_ACK,   // Driving sub-address acknowledge
		ST_WDATA,     // Shifting write data
		ST_WDATA_ACK, // Driving data acknowledge
		ST_RDATA,     // Driving read data bits
		ST_RACK,      // Sampling master acknowledge
		ST_WAIT_STOP  // Released, waiting for stop
	} state_type;

	// ----------------------------------------
	// Line sampling and edge detection
	// ----------------------------------------
	logic scl_d_ff;          // Clock level one cycle ago
	logic sda_d_ff;          // Data level one cycle ago
	logic scl_rise;          // Clock rising edge
	logic scl_fall;          // Clock falling edge
	logic start_det;         // Start or repeated start
	logic stop_det;          // Stop condition

	// Lines are taken as synchronous; only edge history is kept
	always_ff @(posedge clk) begin
		if (rst) begin
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end else begin
			scl_d_ff <= bus.scl;
			sda_d_ff <= bus.sda;
		end
	end

	assign scl_rise = bus.scl & ~scl_d_ff;
	assign scl_fall = ~bus.scl & scl_d_ff;
	assign start_det = bus.scl & scl_d_ff & sda_d_ff & ~bus.sda;
	assign stop_det = bus.scl & scl_d_ff & ~sda_d_ff & bus.sda;

	// ----------------------------------------
	// Power-up access delay
	// ----------------------------------------
	logic [31:0] delay_cnt_ff;  // Cycles since power-up
	logic enabled;              // Port may answer traffic

	// Counts once after reset; ready stays high afterwards
	always_ff @(posedge clk) begin
		if (rst) begin
			delay_cnt_ff <= 32'h0;
			access_ready <= 1'b0;
		end else if (!access_ready) begin
			delay_cnt_ff <= delay_cnt_ff + 32'h1;
			access_ready <= (delay_cnt_ff + 32'h1 >= 32'(ACCESS_DELAY));  // [RULE12]
		end
	end

	assign enabled = access_ready & ~dead_battery;  // [RULE12] [RULE13]

	// ----------------------------------------
	// Byte engine
	// ----------------------------------------
	state_type state_ff;
	logic [7:0] shift_ff;      // Receive or transmit shift register
	logic [2:0] bit_cnt_ff;    // Bits remaining minus one
	logic is_read_ff;          // Current address carried read bit
	logic [7:0] ptr_ff;        // Register pointer
	logic sda_oe_ff;           // Device pulls data low
	logic full_ff;             // Eight bits in, acknowledge due at next fall

	assign reg_addr = ptr_ff;
	assign bus.sda_s_oe = sda_oe_ff;

	// Serial state machine; start and stop override every state
	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff <= ST_IDLE;
			shift_ff <= 8'h00;
			bit_cnt_ff <= 3'h7;
			is_read_ff <= 1'b0;
			full_ff <= 1'b0;
			ptr_ff <= PTR_RESET;  // [RULE11]
			sda_oe_ff <= 1'b0;
			reg_we <= 1'b0;
			reg_wdata <= 8'h00;
		end else begin
			reg_we <= 1'b0;
			if (!enabled) begin
				// Silent: release line and forget the frame
				state_ff <= ST_IDLE;  // [RULE13]
				sda_oe_ff <= 1'b0;
			end else if (start_det) begin
				// Repeated start keeps the pointer from the sub-address
				state_ff <= ST_ADDR;  // [RULE8]
				full_ff <= 1'b0;
				bit_cnt_ff <= 3'h7;
				sda_oe_ff <= 1'b0;
			end else if (stop_det) begin
				// Pointer survives stop, so set-pointer writes work
				state_ff <= ST_IDLE;  // [RULE4] [RULE9]
				sda_oe_ff <= 1'b0;
			end else begin
				case (state_ff)
					ST_IDLE: begin
						sda_oe_ff <= 1'b0;
					end
					ST_ADDR, ST_SUB, ST_WDATA: begin
						// Sample on rising clock, MSB first
						// Counter reads 7 before the first bit and after the eighth;
						// the flag tells them apart, else the fall after a start
						// would be taken for a finished byte
						if (scl_rise) begin
							shift_ff <= {shift_ff[6:0], bus.sda};  // [RULE2]
							bit_cnt_ff <= bit_cnt_ff - 3'h1;
							full_ff <= (bit_cnt_ff == 3'h0);
						end
						if (scl_fall && full_ff && state_ff == ST_ADDR
							&& shift_ff[7:1] != DEV_ADDRESS) begin
							state_ff <= ST_IDLE;  // Not our address
							full_ff <= 1'b0;
						end else if (scl_fall && full_ff) begin
							full_ff <= 1'b0;
							sda_oe_ff <= 1'b1;  // [RULE1] [RULE2] [RULE3]
							case (state_ff)
								ST_ADDR: begin
									is_read_ff <= shift_ff[0];  // [RULE14]
									state_ff <= ST_ADDR_ACK;
								end
								ST_SUB: begin
									ptr_ff <= shift_ff;  // [RULE6] [RULE9]
									state_ff <= ST_SUB_ACK;
								end
								default: begin
									reg_wdata <= shift_ff;  // [RULE3]
									reg_we <= 1'b1;
									state_ff <= ST_WDATA_ACK;
								end
							endcase
						end
					end
					ST_ADDR_ACK, ST_SUB_ACK, ST_WDATA_ACK: begin
						// Acknowledge bit ends on falling clock
						if (scl_fall) begin
							bit_cnt_ff <= 3'h7;
							if (state_ff == ST_WDATA_ACK) begin
								ptr_ff <= ptr_ff + 8'h1;  // [RULE3]
							end
							if (state_ff == ST_ADDR_ACK && is_read_ff) begin
								// Read from pointer: zero, last+1 or sub-address
								shift_ff <= {reg_rdata[6:0], 1'b0};  // [RULE5]
								sda_oe_ff <= ~reg_rdata[7];  // [RULE5]
								state_ff <= ST_RDATA;
							end else begin
								sda_oe_ff <= 1'b0;
								state_ff <= (state_ff == ST_ADDR_ACK) ? ST_SUB : ST_WDATA;
							end
						end
					end
					ST_RDATA: begin
						// Shift next bit out after each falling clock
						if (scl_fall) begin
							if (bit_cnt_ff == 3'h0) begin
								sda_oe_ff <= 1'b0;
								ptr_ff <= ptr_ff + 8'h1;  // [RULE10]
								state_ff <= ST_RACK;
							end else begin
								sda_oe_ff <= ~shift_ff[7];
								shift_ff <= {shift_ff[6:0], 1'b0};
								bit_cnt_ff <= bit_cnt_ff - 3'h1;
							end
						end
					end
					ST_RACK: begin
						// Master answer sampled on rising clock
						if (scl_rise) begin
							if (bus.sda) begin
								state_ff <= ST_WAIT_STOP;  // [RULE7]
							end else begin
								is_read_ff <= 1'b1;
							end
						end else if (scl_fall) begin
							// Pointer already advanced: next register byte
							bit_cnt_ff <= 3'h7;
							shift_ff <= {reg_rdata[6:0], 1'b0};  // [RULE7]
							sda_oe_ff <= ~reg_rdata[7];
							state_ff <= ST_RDATA;
						end
					end
					ST_WAIT_STOP: begin
						sda_oe_ff <= 1'b0;  // [RULE7]
					end
					default: begin
						state_ff <= ST_IDLE;
					end
				endcase
			end
		end
	end

endmodule // i2c_regport_slave

// ### i2c_regport_master.sv
// Master end: issues writes, pointer loads and reads over the two-wire bus
`timescale 1ns/10ps
module i2c_regport_master
	import i2c_regport_pkg::*;
#(
	parameter int HALF_BIT = HALF_BIT_CYC   // Cycles per half bit
) (
	input wire logic clk,
	input wire logic rst,
	i2c_regport_if.master bus,
	input wire logic cmd_valid,          // Request strobe
	input wire i2c_regport_pkg::cmd_type cmd,  // Kind of transfer
	input wire logic [6:0] dev_addr,     // Target address
	input wire logic [7:0] sub_addr,     // Sub-address
	input wire logic [7:0] wr_data,      // Byte to write, taken when wr_ready
	input wire logic wr_last,            // This byte is the last of the write
	input wire logic rd_last,            // NACK the byte now being read
	output logic cmd_ready,              // Idle, may take a request
	output logic wr_ready,               // Pulse: wr_data consumed
	output logic rd_valid,               // Pulse: rd_data holds a byte
	output logic [7:0] rd_data,          // Received byte
	output logic nack_err                // Pulse: device did not acknowledge
);
	import i2c_regport_pkg::*;

	initial begin
		if (HALF_BIT < 2) $error("HALF_BIT must be at least two");
	end

	typedef enum {M_IDLE, M_START, M_BYTE, M_STOP} mstate_type;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	mstate_type st_ff;
	cmd_type cmd_ff;
	logic [15:0] tick_ff;       // Half-bit timer
	logic [3:0] bit_ff;         // Bit 0..8 within byte, 8 is acknowledge
	logic phase_ff;             // 0: clock low half, 1: clock high half
	logic [7:0] tx_ff;          // Byte being sent
	logic [7:0] rx_ff;          // Byte being received
	logic rx_mode_ff;           // Current byte is read data
	logic [1:0] stage_ff;       // 0 addr, 1 sub, 2 data, 3 read address after restart
	logic [1:0] step_ff;        // Start sequence: clock up, data down, clock down
	logic last_ff;              // Stop after this byte
	logic [7:0] sub_ff;
	logic [6:0] dev_ff;
	logic scl_low_ff;
	logic sda_low_ff;
	logic half_done;

	assign bus.scl_oe = scl_low_ff;
	assign bus.sda_m_oe = sda_low_ff;
	assign cmd_ready = (st_ff == M_IDLE);
	assign half_done = (tick_ff == 16'(HALF_BIT - 1));

	// Bit-level timing and byte sequencing
	always_ff @(posedge clk) begin
		if (rst) begin
			st_ff <= M_IDLE;
			cmd_ff <= CMD_WRITE;
			tick_ff <= 16'h0;
			bit_ff <= 4'h0;
			phase_ff <= 1'b0;
			tx_ff <= 8'h00;
			rx_ff <= 8'h00;
			rx_mode_ff <= 1'b0;
			stage_ff <= 2'h0;
			step_ff <= 2'h0;
			last_ff <= 1'b0;
			sub_ff <= 8'h00;
			dev_ff <= 7'h00;
			scl_low_ff <= 1'b0;
			sda_low_ff <= 1'b0;
			wr_ready <= 1'b0;
			rd_valid <= 1'b0;
			rd_data <= 8'h00;
			nack_err <= 1'b0;
		end else begin
			wr_ready <= 1'b0;
			rd_valid <= 1'b0;
			nack_err <= 1'b0;
			tick_ff <= half_done ? 16'h0 : tick_ff + 16'h1;
			case (st_ff)
				M_IDLE: begin
					tick_ff <= 16'h0;
					if (cmd_valid) begin
						cmd_ff <= cmd;
						sub_ff <= sub_addr;
						dev_ff <= dev_addr;
						st_ff <= M_START;
						phase_ff <= 1'b0;
						// Fresh frame: no leftover stage may pose as a restart
						stage_ff <= 2'h0;
						step_ff <= 2'h0;
					end
				end
				M_START: begin
					// Clock up first, so a repeated start also finds it high
					if (half_done) begin
						case (step_ff)
							2'h0: begin
								scl_low_ff <= 1'b0;
								step_ff <= 2'h1;
							end
							2'h1: begin
								// Data falls while clock high
								sda_low_ff <= 1'b1;
								step_ff <= 2'h2;
							end
							default: begin
								scl_low_ff <= 1'b1;
								phase_ff <= 1'b0;
								bit_ff <= 4'h0;
								rx_mode_ff <= 1'b0;
								last_ff <= 1'b0;
								st_ff <= M_BYTE;
								// Plain read and the restarted address carry direction one
								tx_ff <= {dev_ff, cmd_ff == CMD_READ_CUR || stage_ff == 2'h1};
								stage_ff <= (stage_ff == 2'h1) ? 2'h3 : 2'h0;
							end
						endcase
					end
				end
				M_BYTE: begin
					if (half_done && !phase_ff) begin
						// Clock low half over: bit already driven, raise clock
						scl_low_ff <= 1'b0;
						phase_ff <= 1'b1;
					end else if (half_done) begin
						scl_low_ff <= 1'b1;
						phase_ff <= 1'b0;
						if (bit_ff < 4'h8 && rx_mode_ff) begin
							rx_ff <= {rx_ff[6:0], bus.sda};
						end
						bit_ff <= bit_ff + 4'h1;
						if (bit_ff == 4'h8) begin
							bit_ff <= 4'h0;
							if (rx_mode_ff) begin
								rd_data <= rx_ff;
								rd_valid <= 1'b1;
							end else if (bus.sda) begin
								nack_err <= 1'b1;
								last_ff <= 1'b1;
							end
							if (last_ff || (!rx_mode_ff && bus.sda)) begin
								st_ff <= M_STOP;
							end else if (stage_ff == 2'h0 && (cmd_ff == CMD_READ_CUR)) begin
								rx_mode_ff <= 1'b1;
								stage_ff <= 2'h2;
							end else if (stage_ff == 2'h0) begin
								tx_ff <= sub_ff;
								stage_ff <= 2'h1;
								last_ff <= (cmd_ff == CMD_SET_PTR);
							end else if (stage_ff == 2'h1 && cmd_ff == CMD_READ_SUB) begin
								// Data already released in the ack slot; clock stays low
								st_ff <= M_START;
								step_ff <= 2'h0;
							end else if (stage_ff == 2'h3) begin
								// Read address after repeated start acknowledged
								rx_mode_ff <= 1'b1;
								stage_ff <= 2'h2;
							end else if (stage_ff == 2'h2 && rx_mode_ff) begin
								rx_mode_ff <= 1'b1;
							end else begin
								tx_ff <= wr_data;
								wr_ready <= 1'b1;
								last_ff <= wr_last;
								stage_ff <= 2'h2;
							end
						end
					end else if (tick_ff == 16'h0 && !phase_ff) begin
						// Drive data during clock low
						if (bit_ff < 4'h8) begin
							sda_low_ff <= rx_mode_ff ? 1'b0 : ~tx_ff[3'(4'h7 - bit_ff)];
						end else begin
							sda_low_ff <= rx_mode_ff ? ~rd_last : 1'b0;
							if (rx_mode_ff) last_ff <= rd_last;
						end
					end
				end
				M_STOP: begin
					// Data low, clock high, then data high
					if (tick_ff == 16'h0 && !phase_ff) begin
						sda_low_ff <= 1'b1;
					end else if (half_done && !phase_ff) begin
						scl_low_ff <= 1'b0;
						phase_ff <= 1'b1;
					end else if (half_done) begin
						sda_low_ff <= 1'b0;
						phase_ff <= 1'b0;
						st_ff <= M_IDLE;
					end
				end
				default: begin
					st_ff <= M_IDLE;
				end
			endcase
		end
	end

endmodule // i2c_regport_master

// ### i2c_regport_checker.sv
// Wire-level checker for the two-wire register port and its master
`timescale 1ns/10ps
module i2c_regport_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic scl_oe,
	input wire logic sda_m_oe,
	input wire logic sda_s_oe,
	input wire logic scl,
	input wire logic sda
);
	// ----------------------------------------
	// Bus event tracking
	// ----------------------------------------
	logic scl_q_ff; // Clock one cycle ago
	logic sda_q_ff; // Data one cycle ago
	logic [3:0] bit_cnt_ff; // Clock rises in byte, 9 is ack slot
	logic [7:0] shift_ff; // Bits seen this byte
	logic first_ff; // Address byte in progress
	logic acked_ff; // Address acknowledged
	logic rd_ff; // Read direction acknowledged
	logic nack_ff; // Master refused a read byte
	logic in_frame_ff; // Between start and stop
	wire scl_rise = scl & ~scl_q_ff;
	wire start_ev = scl & scl_q_ff & sda_q_ff & ~sda;
	wire stop_ev = scl & scl_q_ff & ~sda_q_ff & sda;
	// Line history for edge and condition detection
	always_ff @(posedge clk) begin
		scl_q_ff <= scl;
		sda_q_ff <= sda;
	end
	// Bit counter, restarted by every start
	always_ff @(posedge clk) begin
		if (rst || start_ev) begin
			bit_cnt_ff <= 4'h0;
		end else if (scl_rise) begin
			bit_cnt_ff <= (bit_cnt_ff == 4'h9) ? 4'h1 : bit_cnt_ff + 4'h1;
		end
	end
	// Shifter skips the ack slot so bit 0 is the direction bit
	always_ff @(posedge clk) begin
		if (scl_rise && bit_cnt_ff != 4'h8) begin
			shift_ff <= {shift_ff[6:0], sda};
		end
	end
	// Frame flags; a stop or start clears all history
	always_ff @(posedge clk) begin
		if (rst || start_ev || stop_ev) begin
			first_ff <= start_ev && !rst;
			in_frame_ff <= start_ev && !rst;
			acked_ff <= 1'b0;
			rd_ff <= 1'b0;
			nack_ff <= 1'b0;
		end else if (scl_rise && bit_cnt_ff == 4'h8) begin
			first_ff <= 1'b0;
			if (first_ff) begin
				acked_ff <= ~sda;
				rd_ff <= shift_ff[0] & ~sda;
			end else if (rd_ff && sda) begin
				nack_ff <= 1'b1;
			end
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence ack_slot;
		scl_rise && bit_cnt_ff == 4'h8;
	endsequence
	sequence wr_ack_slot;
		ack_slot ##0 (acked_ff && !first_ff && !rd_ff);
	endsequence
	sequence rd_ack_slot;
		ack_slot ##0 (rd_ff && !first_ff);
	endsequence
	slave_hold_a: assert property (scl && $past(scl) |-> $stable(sda_s_oe))
		else $error("device data moved while clock high");
	write_ack_a: assert property (wr_ack_slot |-> !sda)
		else $error("written byte not acknowledged");
	ack_slot_free_a: assert property (rd_ack_slot |-> !sda_s_oe)
		else $error("device drove master ack slot");
	nack_release_a: assert property (nack_ff |-> !sda_s_oe)
		else $error("device drove data after refusal");
	idle_release_a: assert property (!in_frame_ff |-> !sda_s_oe)
		else $error("device drove idle bus");
	master_hold_a: assert property (scl && $past(scl) && bit_cnt_ff >= 4'h2 |-> $stable(sda_m_oe))
		else $error("master data moved while clock high");
	idle_clock_a: assert property (!in_frame_ff |-> !scl_oe)
		else $error("clock pulled outside frame");
	whole_byte_a: assert property (stop_ev || (start_ev && in_frame_ff) |-> bit_cnt_ff == 4'h1)
		else $error("frame ended inside a byte");
	frame_clock_a: assert property (start_ev && !in_frame_ff |-> ##[1:40] scl_rise)
		else $error("no clock after start");
endmodule // i2c_regport_checker

// ### i2c_register_access_slave_tb.sv
// Testbench: master and register port joined over the two-wire bus
`timescale 1ns/10ps
`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin n_fail++; \
	$display("BAD %s expected %h seen %h", what, exp, got); end end
module i2c_register_access_slave_tb;
	import i2c_regport_pkg::*;
	// ----------------------------------------
	// Signals and register map model
	// ----------------------------------------
	logic clk = 1'b0;
	logic rst, dead_battery, reg_we, access_ready;
	logic [7:0] reg_rdata, reg_addr, reg_wdata;
	logic cmd_valid, wr_last, rd_last, cmd_ready, wr_ready, rd_valid, nack_err;
	cmd_type cmd;
	logic [6:0] dev_addr;
	logic [7:0] sub_addr, wr_data, rd_data;
	logic [7:0] mem [256]; // Register map behind the port
	logic [7:0] wq [4]; // Bytes for the next write
	logic [7:0] rd_q [$]; // Bytes received by the master
	logic nack_seen; // Master reported a refusal
	int n_fail = 0, compares = 0, n_we = 0, nr = 0, nw = 0, widx = 0, t, w0;
	assign reg_rdata = mem[reg_addr];
	always #5 clk = ~clk;
	i2c_regport_if i2c_regport_if_inst ();
	i2c_regport_slave #(.DEV_ADDRESS(DEV_ADDR), .ACCESS_DELAY(200)) i2c_regport_slave_inst (
		.clk(clk), .rst(rst), .bus(i2c_regport_if_inst), .dead_battery(dead_battery),
		.reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_we(reg_we), .access_ready(access_ready));
	i2c_regport_master #(.HALF_BIT(4)) i2c_regport_master_inst (
		.clk(clk), .rst(rst), .bus(i2c_regport_if_inst), .cmd_valid(cmd_valid), .cmd(cmd),
		.dev_addr(dev_addr), .sub_addr(sub_addr), .wr_data(wr_data), .wr_last(wr_last),
		.rd_last(rd_last), .cmd_ready(cmd_ready), .wr_ready(wr_ready), .rd_valid(rd_valid),
		.rd_data(rd_data), .nack_err(nack_err));
	i2c_regport_checker i2c_regport_checker_inst (
		.clk(clk), .rst(rst), .scl_oe(i2c_regport_if_inst.scl_oe),
		.sda_m_oe(i2c_regport_if_inst.sda_m_oe), .sda_s_oe(i2c_regport_if_inst.sda_s_oe),
		.scl(i2c_regport_if_inst.scl), .sda(i2c_regport_if_inst.sda));
	// Register stores, read capture and write byte feed
	always @(posedge clk) begin
		if (reg_we === 1'b1) begin
			mem[reg_addr] <= reg_wdata;
			n_we++;
		end
		if (nack_err === 1'b1) nack_seen = 1'b1;
		if (rd_valid === 1'b1) begin
			rd_q.push_back(rd_data);
			rd_last <= (rd_q.size() >= nr - 1); // Refuse the last wanted byte
		end
		if (wr_ready === 1'b1) begin
			widx++;
			wr_data <= wq[widx];
			wr_last <= (widx == nw - 1);
		end
	end
	// ----------------------------------------
	// Transfer tasks
	// ----------------------------------------
	// One whole transaction; waits for the master to go idle again
	task automatic run(input cmd_type c, input logic [6:0] a, input logic [7:0] s, input int n);
		rd_q.delete();
		nack_seen = 1'b0;
		nr = n;
		nw = n;
		widx = 0;
		cmd <= c;
		dev_addr <= a;
		sub_addr <= s;
		wr_data <= wq[0];
		wr_last <= (n == 1);
		rd_last <= (n == 1);
		cmd_valid <= 1'b1;
		@(posedge clk);
		cmd_valid <= 1'b0;
		t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (cmd_ready !== 1'b1 && t < 4000);
		`CHK("done", 1'b1, cmd_ready);
		repeat (4) @(posedge clk);
	endtask
	// Received bytes against successive map locations
	task automatic chk_rd(input logic [7:0] base, input int n);
		`CHK("read count", n, rd_q.size());
		for (int i = 0; i < n; i++) begin
			`CHK("read byte", mem[8'(base + i)], rd_q[i]);
		end
	endtask
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Sequence of tests
	// ----------------------------------------
	initial begin
		rst <= 1'b1;
		dead_battery <= 1'b0;
		cmd_valid <= 1'b0;
		cmd <= CMD_WRITE;
		dev_addr <= DEV_ADDR;
		sub_addr <= 8'h00;
		wr_data <= 8'h00;
		wr_last <= 1'b0;
		rd_last <= 1'b0;
		for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		`CHK("not ready", 1'b0, access_ready);
		`CHK("pointer", 8'h00, reg_addr);
		// Too early: no answer
		run(CMD_READ_CUR, DEV_ADDR, 8'h00, 1);
		`CHK("early refusal", 1'b1, nack_seen);
		`CHK("early bytes", 0, rd_q.size());
		t = 0;
		while (access_ready !== 1'b1 && t < 1000) begin
			@(posedge clk);
			t++;
		end
		`CHK("ready", 1'b1, access_ready);
		// First reads from zero, then continue after the refused byte
		run(CMD_READ_CUR, DEV_ADDR, 8'h00, 3);
		chk_rd(8'h00, 3);
		run(CMD_READ_CUR, DEV_ADDR, 8'h00, 2);
		chk_rd(8'h03, 2);
		// Pointer load stores nothing
		w0 = n_we;
		run(CMD_SET_PTR, DEV_ADDR, 8'h40, 1);
		`CHK("stores", w0, n_we);
		run(CMD_READ_CUR, DEV_ADDR, 8'h00, 2);
		chk_rd(8'h40, 2);
		// Burst across the top of the map
		wq[0] = 8'h11;
		wq[1] = 8'h22;
		wq[2] = 8'h33;
		w0 = n_we;
		run(CMD_WRITE, DEV_ADDR, 8'hFE, 3);
		`CHK("stores", w0 + 3, n_we);
		`CHK("byte FE", 8'h11, mem[8'hFE]);
		`CHK("byte FF", 8'h22, mem[8'hFF]);
		`CHK("byte 00", 8'h33, mem[8'h00]);
		run(CMD_READ_SUB, DEV_ADDR, 8'hFE, 3);
		chk_rd(8'hFE, 3);
		`CHK("combined first", 8'h11, rd_q[0]);
		// Dead battery: silent port
		dead_battery <= 1'b1;
		@(posedge clk);
		wq[0] = 8'hC3;
		run(CMD_WRITE, DEV_ADDR, 8'h10, 1);
		`CHK("silent refusal", 1'b1, nack_seen);
		`CHK("kept byte", 8'h4A, mem[8'h10]);
		dead_battery <= 1'b0;
		@(posedge clk);
		// Foreign address is not acknowledged
		run(CMD_READ_SUB, DEV_ADDR ^ 7'h01, 8'h10, 1);
		`CHK("foreign refusal", 1'b1, nack_seen);
		`CHK("foreign bytes", 0, rd_q.size());
		complete_run();
	end
	// Watchdog well beyond the expected run length
	initial begin
		repeat (40000) @(posedge clk);
		n_fail++;
		$display("BAD watchdog expected finish seen hang");
		complete_run();
	end
endmodule // i2c_register_access_slave_tb
